/* rtl/rtc_regs.svh */
// Register offsets, field positions and reset values for the transmit configuration bank
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

`define RTC_ADDR_W 32
`define RTC_OFS_CHGROUP 32'h500010CC
`define RTC_OFS_TXCTRL 32'h50010100
`define RTC_OFS_TXGAIN 32'h50010104

`define RTC_CHG_LO_LSB 0
`define RTC_CHG_HI_LSB 8
`define RTC_CHG_MASK 32'h0000FFFF

`define RTC_TXC_INV_BIT 2
`define RTC_TXC_MASK 32'h000700FF
`define RTC_TXG_MASK 32'hF8000FFF

`define RTC_CHG_RESET 32'h00000000
`define RTC_TXC_RESET 32'h00000000
`define RTC_TXG_RESET 32'h00000000

`define RTC_RESP_OKAY 2'h0
`define RTC_RESP_SLVERR 2'h2

`endif

/* rtl/rtc_pkg.sv */
// Types shared by the transmit configuration bank
package rtc_pkg;

  typedef struct packed {
    logic [7:0] groupHighBound;
    logic [7:0] groupLowBound;
  } rtc_chgroup_t;

  typedef struct packed {
    logic [2:0] gaussBtCode;
    logic delayFitSource;
    logic turboFitSelect;
    logic deviationScale;
    logic gaussRateSelect;
    logic gaussFilterOn;
    logic txDataInvert;
    logic oscModEnable;
    logic txModEnable;
  } rtc_txctrl_t;

  typedef struct packed {
    logic [4:0] ampPowerCtl;
    logic [1:0] ampVoltageCode;
    logic ampBiasHighCurrent;
    logic ampHighCurrent;
    logic gainReservedBit;
    logic txCurrentSelect;
    logic [2:0] ampCurrentCode;
    logic [2:0] txBufferCode;
  } rtc_txgain_t;

  typedef enum logic [1:0] {
    RTC_SEL_NONE,
    RTC_SEL_CHG,
    RTC_SEL_TXC,
    RTC_SEL_TXG
  } rtc_sel_t;

endpackage

/* rtl/rtc_wr_merge.sv */
// Byte-lane write merge under a field mask
`timescale 1ns/10ps
`default_nettype none
module rtc_wr_merge (
  // Old value and write
  input wire logic [31:0] oldVal,
  input wire logic [31:0] wrData,
  input wire logic [3:0] wrStrb,
  input wire logic [31:0] fieldMask,
  // Result
  output logic [31:0] newVal
);
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gLane
      // Bits without a field stay zero whatever is written
      assign newVal[8*g +: 8] = (wrStrb[g] ? wrData[8*g +: 8] : oldVal[8*g +: 8])
                                & fieldMask[8*g +: 8];
    end
  endgenerate
endmodule
`default_nettype wire

/* rtl/rtc_read_mux.sv */
// Read data selection for the transmit configuration bank
`timescale 1ns/10ps
`default_nettype none
module rtc_read_mux
  import rtc_pkg::*;
(
  // Selection
  input wire rtc_sel_t sel,
  // Stored values
  input wire logic [31:0] chgVal,
  // Read data
  output logic [31:0] rdVal
);
  always_comb begin
    case (sel)
      RTC_SEL_CHG: rdVal = chgVal;
      // Write-only registers give no read path
      RTC_SEL_TXC: rdVal = 32'h00000000;
      RTC_SEL_TXG: rdVal = 32'h00000000;
      default: rdVal = 32'h00000000;
    endcase
  end
endmodule
`default_nettype wire

/* rtl/rtc_config_regs.sv */
// AXI4-Lite bank holding channel group bounds and transmit control and gain
//
// Contract
// - Low bound in bits 7:0, read-write
// - High bound in bits 15:8, read-write
// - Delay-fit source bit selects preamble or sync data
// - Turbo fit bit selects carrier or preamble
// - Deviation scale bit gives 1x or 0.9x
// - Rate bit selects bandwidth-time range
// - Filter bit bypasses or applies Gaussian filter
// - Invert bit inverts every transmit data bit
// - Oscillator and general modulation enables
// - Three-bit code in 18:16 picks bandwidth-time
// - Gain bits: buffer 2:0, current 5:3, select 6
`timescale 1ns/10ps
`default_nettype none
`include "rtc_regs.svh"
module rtc_config_regs
  import rtc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // AXI4-Lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Channel group bounds to the synthesizer
  output rtc_chgroup_t chGroup,
  // Transmit control settings
  output rtc_txctrl_t txCtrl,
  // Transmit gain settings
  output rtc_txgain_t txGain,
  // Transmit data path
  input wire logic txDataIn,
  output logic txDataOut
);

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic rtc_sel_t decodeAddr(input logic [31:0] addr);
    case (addr)
      `RTC_OFS_CHGROUP: decodeAddr = RTC_SEL_CHG;
      `RTC_OFS_TXCTRL: decodeAddr = RTC_SEL_TXC;
      `RTC_OFS_TXGAIN: decodeAddr = RTC_SEL_TXG;
      default: decodeAddr = RTC_SEL_NONE;
    endcase
  endfunction

  logic [31:0] chg_reg;
  logic [31:0] txc_reg;
  logic [31:0] txg_reg;
  logic [31:0] chg_next;
  logic [31:0] txc_next;
  logic [31:0] txg_next;

  ////////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data latched independently, in either order

  logic awHeld_reg;
  logic wHeld_reg;
  logic [31:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic doWrite;
  rtc_sel_t wrSel;

  assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
  assign wrSel = decodeAddr(awAddr_reg);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= 32'h00000000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_reg <= 1'b1;
      awAddr_reg <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wHeld_reg <= 1'b0;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_reg <= 1'b1;
      wData_reg <= s_axi_wdata;
      wStrb_reg <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld_reg <= 1'b0;
    end
  end

  // Ready only while the slot is empty, so a held item is never overwritten
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !awHeld_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !wHeld_reg && !(s_axi_wvalid && s_axi_wready);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RTC_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wrSel == RTC_SEL_NONE) ? `RTC_RESP_SLVERR : `RTC_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage

  rtc_wr_merge uChgMerge (
    .oldVal(chg_reg),
    .wrData(wData_reg),
    .wrStrb(wStrb_reg),
    .fieldMask(`RTC_CHG_MASK),
    .newVal(chg_next)
  );

  rtc_wr_merge uTxcMerge (
    .oldVal(txc_reg),
    .wrData(wData_reg),
    .wrStrb(wStrb_reg),
    .fieldMask(`RTC_TXC_MASK),
    .newVal(txc_next)
  );

  // Internal gain fields are stored as written; software keeps them intact
  rtc_wr_merge uTxgMerge (
    .oldVal(txg_reg),
    .wrData(wData_reg),
    .wrStrb(wStrb_reg),
    .fieldMask(`RTC_TXG_MASK),
    .newVal(txg_next)
  );

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      chg_reg <= `RTC_CHG_RESET;
    end else if (doWrite && wrSel == RTC_SEL_CHG) begin
      chg_reg <= chg_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      txc_reg <= `RTC_TXC_RESET;
    end else if (doWrite && wrSel == RTC_SEL_TXC) begin
      txc_reg <= txc_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      txg_reg <= `RTC_TXG_RESET;
    end else if (doWrite && wrSel == RTC_SEL_TXG) begin
      txg_reg <= txg_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Field outputs, registered so settings change one cycle after the store

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      chGroup <= '0;
      txCtrl <= '0;
      txGain <= '0;
    end else begin
      chGroup.groupLowBound <= chg_reg[`RTC_CHG_LO_LSB +: 8];
      chGroup.groupHighBound <= chg_reg[`RTC_CHG_HI_LSB +: 8];
      txCtrl.delayFitSource <= txc_reg[7];
      txCtrl.turboFitSelect <= txc_reg[6];
      txCtrl.deviationScale <= txc_reg[5];
      txCtrl.gaussRateSelect <= txc_reg[4];
      txCtrl.gaussFilterOn <= txc_reg[3];
      txCtrl.txDataInvert <= txc_reg[2];
      txCtrl.oscModEnable <= txc_reg[1];
      txCtrl.txModEnable <= txc_reg[0];
      txCtrl.gaussBtCode <= txc_reg[18:16];
      txGain.txBufferCode <= txg_reg[2:0];
      txGain.ampCurrentCode <= txg_reg[5:3];
      txGain.txCurrentSelect <= txg_reg[6];
      txGain.gainReservedBit <= txg_reg[7];
      txGain.ampHighCurrent <= txg_reg[8];
      txGain.ampBiasHighCurrent <= txg_reg[9];
      txGain.ampVoltageCode <= txg_reg[11:10];
      txGain.ampPowerCtl <= txg_reg[31:27];
    end
  end

  // Inversion applied in the block so the data path sees it with one stage of latency
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      txDataOut <= 1'b0;
    end else begin
      txDataOut <= txDataIn ^ txc_reg[`RTC_TXC_INV_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read channel

  logic [31:0] rdVal;
  rtc_sel_t rdSel;

  assign rdSel = decodeAddr(s_axi_araddr);

  rtc_read_mux uReadMux (
    .sel(rdSel),
    .chgVal(chg_reg),
    .rdVal(rdVal)
  );

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RTC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdVal;
      s_axi_rresp <= (rdSel == RTC_SEL_NONE) ? `RTC_RESP_SLVERR : `RTC_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* verif/rtc_config_regs_assertions.sv */
// Port checks for the transmit configuration bank
`timescale 1ns/10ps
`default_nettype none
`include "rtc_regs.svh"
module rtc_config_regs_assertions
  import rtc_pkg::*;
(
  // Clock, reset and bus
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Settings and data path
  input wire rtc_chgroup_t chGroup,
  input wire rtc_txctrl_t txCtrl,
  input wire logic txDataIn,
  input wire logic txDataOut
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic arHit;
  assign arHit = s_axi_arvalid && s_axi_arready;
  ////////////////////////////////////////////////////////////////////////////
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_read_latency: assert property (arHit |=> s_axi_rvalid) else $error("rvalid late");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar early");
  a_ctrl_reads_zero: assert property (arHit && s_axi_araddr inside
    {`RTC_OFS_TXCTRL, `RTC_OFS_TXGAIN} |=> s_axi_rdata == 32'h0 && s_axi_rresp == 2'h0)
    else $error("write-only read");
  a_group_reads: assert property (arHit && s_axi_araddr == `RTC_OFS_CHGROUP |=>
    s_axi_rdata == {16'h0000, chGroup} && s_axi_rresp == 2'h0) else $error("group read");
  a_unmapped_err: assert property (arHit && !(s_axi_araddr inside {`RTC_OFS_CHGROUP,
    `RTC_OFS_TXCTRL, `RTC_OFS_TXGAIN}) |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read");
  a_invert_path: assert property (!$past(srst) && txCtrl == $past(txCtrl) &&
    txCtrl == $past(txCtrl, 2) |-> txDataOut == ($past(txDataIn) ^ txCtrl.txDataInvert))
    else $error("invert path");
endmodule
bind rtc_config_regs rtc_config_regs_assertions chk_u (.*);
`default_nettype wire

/* verif/rtc_config_regs_test.sv */
// Self-checking bench for the transmit configuration bank
`timescale 1ns/10ps
`default_nettype none
`include "rtc_regs.svh"
module rtc_config_regs_test import rtc_pkg::*; ;
  logic sys_clk, srst, txDataIn, txDataOut;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  rtc_chgroup_t chGroup;
  rtc_txctrl_t txCtrl;
  rtc_txgain_t txGain;
  logic [33:0] rq[$], bq[$];
  logic [31:0] seed, tds, d, bm;
  logic [31:0] m[4];
  logic [3:0] s;
  int bad_count, compares;
  // Last slot is an unmapped address just past the bank
  localparam logic [31:0] AD[4] = '{`RTC_OFS_CHGROUP, `RTC_OFS_TXCTRL, `RTC_OFS_TXGAIN,
    32'h50010108};
  localparam logic [31:0] MK[4] = '{`RTC_CHG_MASK, `RTC_TXC_MASK, `RTC_TXG_MASK, 32'h0};
  rtc_config_regs dut_u (.*);
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 0;
    forever #4 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("bad_count=%0d compares=%0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Each channel released on its own handshake; bready held until bvalid
  task automatic wr(input logic [31:0] ad, input logic [1:0] r);
    logic ta, tw;
    ta = 0;
    tw = 0;
    @(posedge sys_clk);
    bq.push_back({32'h0, r});
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      ta |= s_axi_awready;
      tw |= s_axi_wready;
    end
    while (!s_axi_bvalid) @(posedge sys_clk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] ad, input logic [33:0] e);
    @(posedge sys_clk);
    rq.push_back(e);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  // Write, check outputs against the model, read back
  task automatic step(input int k);
    if (k == 2) d = (d & ~32'hF8000F80) | (m[2] & 32'hF8000F80);
    bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    wr(AD[k], k == 3 ? `RTC_RESP_SLVERR : `RTC_RESP_OKAY);
    m[k] = (m[k] & ~bm) | (d & bm & MK[k]);
    repeat (3) @(posedge sys_clk);
    chk({18'h0, chGroup}, {18'h0, m[0][15:0]});
    chk({23'h0, txCtrl}, {23'h0, m[1][18:16], m[1][7:0]});
    chk({17'h0, txGain}, {17'h0, m[2][31:27], m[2][11:0]});
    rd(AD[k], k == 0 ? {2'h0, m[0]} : {k == 3 ? `RTC_RESP_SLVERR : `RTC_RESP_OKAY, 32'h0});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready) chk({32'h0, s_axi_bresp}, bq.pop_front());
  end
  always @(posedge sys_clk) begin
    tds <= xs(tds);
    txDataIn <= tds[0];
  end
  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    srst = 1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
    m = '{default: 32'h0};
    seed = 32'h5581;
    tds = 32'h5581;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    for (int k = 0; k < 4; k++) rd(AD[k], {k == 3 ? 2'h2 : 2'h0, 32'h0});
    s = 4'hF;
    d = 32'h0000783C;
    step(0);
    for (int i = 0; i < 80; i++) begin
      seed = xs(seed);
      d = seed;
      seed = xs(seed);
      s = seed[3:0];
      step(seed[9:8]);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
